//--- design/spu_storage_protect.sv
// storage protection unit with barricade, trap vector and mode tracking
`timescale 1ns/100ps
`default_nettype none
module spu_storage_protect
	import spu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic loadBarricade,
	input wire logic [SPU_BANK_W-1:0] loadBank,
	input wire logic restoreIndicators,
	input wire logic restoreProtect,
	input wire logic restoreProceed,
	input wire logic storeIndicators,
	input wire logic resumeNormal,
	input wire logic resumeToInternal,
	input wire logic extIntTake,
	input wire logic extIntPending,
	input wire logic runMode,
	input wire logic aboutToFetch,
	input wire logic memCycle,
	input wire logic opFetch,
	input wire logic opPrivileged,
	input wire logic [SPU_AW-1:0] seqAddr,
	input wire logic resultWrite,
	input wire logic [SPU_AW-1:0] resultAddr,
	input wire logic instrIsTransfer,
	input wire logic transferExtract,
	input wire logic [SPU_AW-1:0] transferStart,
	input wire logic fourCharMode,
	input wire logic [SPU_MOD_W-1:0] addrModifier,
	output logic trapTake,
	output logic [SPU_AW-1:0] trapVector,
	output logic writeInhibit,
	output logic transferAbort,
	output logic opAbort,
	output logic fifthVariantBit1,
	output logic bankIndexSelect,
	output logic [SPU_AW-1:0] bankIndexAddr
);
	spu_mode_type mode;
	spu_mode_type next_mode;
	logic [SPU_BANK_W-1:0] barricade;
	logic barricadeLoaded;
	logic protectInd;
	logic proceedInd;
	logic addrViolInt;
	logic addrViolExt;
	logic opViol;
	logic preempted;
	logic violInstr;
	logic [SPU_AW-1:0] vector;
	logic apbWrite;
	logic apbRead;
	logic writeViolNow;
	logic transferCheck;
	logic transferViolNow;
	logic opViolNow;
	logic setAddrInt;
	logic isStd;
	logic [3:0] idxSel;
	logic [5:0] idxOffset;

	assign isStd = (mode == MODE_STD);
	assign apbWrite = psel & penable & pwrite;
	// read data is fetched in setup so it already stands through the access phase
	assign apbRead = psel & ~penable & ~pwrite;

	// only the bank bits matter: the barricade always sits on a bank base
	function automatic logic inProtected(input logic [SPU_AW-1:0] addr,
		input logic [SPU_BANK_W-1:0] bar);
		inProtected = (addr[SPU_AW-1:SPU_BANK_LSB] >= bar); // R1 R2
	endfunction : inProtected

	assign writeViolNow = resultWrite & inProtected(resultAddr, barricade) & protectInd
		& isStd & ~instrIsTransfer; // R13 R14 R3
	assign transferCheck = proceedInd & ((isStd & protectInd) | ~isStd); // R20 R3
	assign transferViolNow = transferExtract & transferCheck
		& inProtected(transferStart, barricade); // R17 R18
	assign opViolNow = opFetch & opPrivileged & isStd & protectInd & ~proceedInd; // R21
	assign setAddrInt = writeViolNow | (transferViolNow & (mode != MODE_EXT));
	assign trapTake = (addrViolInt | opViol) & runMode & aboutToFetch & memCycle & isStd
		& ~extIntPending; // R7 R11
	assign trapVector = vector; // R8
	assign writeInhibit = writeViolNow | violInstr; // R15
	assign transferAbort = transferViolNow; // R17
	assign opAbort = opViolNow; // R21
	assign fifthVariantBit1 = preempted; // R12

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			barricade <= SPU_BARRICADE_RST;
			barricadeLoaded <= 1'b0;
		end else if (loadBarricade) begin
			barricade <= loadBank; // R1
			barricadeLoaded <= 1'b1;
		end else if (apbWrite && paddr == SPU_OFF_BARRICADE) begin
			barricade <= pwdata[SPU_BANK_W-1:0];
			barricadeLoaded <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			protectInd <= 1'b0;
		end else if (restoreIndicators) begin
			protectInd <= restoreProtect; // R3
		end else if (apbWrite && paddr == SPU_OFF_CTRL) begin
			protectInd <= pwdata[SPU_CTRL_PROTECT];
		end
	end

	// a restore in the same cycle as a fetch wins: it arms the next op
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			proceedInd <= 1'b0;
		end else if (restoreIndicators) begin
			proceedInd <= restoreProceed;
		end else if (apbWrite && paddr == SPU_OFF_CTRL) begin
			proceedInd <= pwdata[SPU_CTRL_PROCEED];
		end else if (opFetch && isStd) begin
			proceedInd <= 1'b0; // R22
		end else if (storeIndicators && !isStd) begin
			proceedInd <= 1'b0; // R22
		end
	end

	// set wins over the store-indicators clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addrViolInt <= 1'b0;
		end else if (setAddrInt) begin
			addrViolInt <= 1'b1; // R15 R17
		end else if (storeIndicators) begin
			addrViolInt <= 1'b0; // R10
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addrViolExt <= 1'b0;
		end else if (transferViolNow && mode == MODE_EXT) begin
			addrViolExt <= 1'b1; // R20
		end else if (storeIndicators) begin
			addrViolExt <= 1'b0; // R10
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			opViol <= 1'b0;
		end else if (opViolNow) begin
			opViol <= 1'b1; // R21
		end else if (storeIndicators) begin
			opViol <= 1'b0; // R10
		end
	end

	// write inhibit lasts until the next op fetch ends the instruction
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			violInstr <= 1'b0;
		end else if (writeViolNow) begin
			violInstr <= 1'b1; // R15
		end else if (opFetch) begin
			violInstr <= 1'b0;
		end
	end

	// sequencer already points past the faulting op, so the swap saves that address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vector <= SPU_VECTOR_RST;
		end else if (trapTake) begin
			vector <= seqAddr; // R8 R16
		end else if (apbWrite && paddr == SPU_OFF_VECTOR) begin
			vector <= pwdata[SPU_AW-1:0];
		end
	end

	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_STD: begin
				if (extIntTake) begin
					next_mode = MODE_EXT;
				end else if (trapTake) begin
					next_mode = MODE_INT; // R8 R9
				end
			end
			MODE_INT: begin
				if (extIntTake) begin
					next_mode = MODE_EXT; // R11
				end else if (resumeNormal) begin
					next_mode = MODE_STD;
				end
			end
			MODE_EXT: begin
				if (resumeNormal) begin
					next_mode = resumeToInternal ? MODE_INT : MODE_STD; // R12
				end
			end
			default: begin
				next_mode = MODE_STD;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode <= MODE_STD;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			preempted <= 1'b0;
		end else if (extIntTake && mode == MODE_INT) begin
			preempted <= 1'b1; // R12
		end else if (resumeNormal && mode == MODE_EXT) begin
			preempted <= 1'b0;
		end
	end

	// bank index register n occupies four characters at offset 4*(n-1)
	assign idxSel = addrModifier[3:0] - SPU_IDX_ONE;
	assign idxOffset = {idxSel, 2'b00};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bankIndexSelect <= 1'b0;
			bankIndexAddr <= '0;
		end else begin
			bankIndexSelect <= fourCharMode & addrModifier[SPU_MOD_W-1]
				& (addrModifier[3:0] != SPU_IDX_NONE) & barricadeLoaded; // R5 R6
			bankIndexAddr <= {barricade, SPU_BANK_BASE}
				+ {{(SPU_AW-6){1'b0}}, idxOffset}; // R4
		end
	end

	// single-cycle access phase; unmapped addresses answer with an error
	assign pready = 1'b1;
	always_comb begin
		if (paddr == SPU_OFF_CTRL || paddr == SPU_OFF_BARRICADE
			|| paddr == SPU_OFF_VECTOR || paddr == SPU_OFF_STATUS) begin
			pslverr = 1'b0;
		end else begin
			pslverr = psel & penable;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (apbRead) begin
			if (paddr == SPU_OFF_CTRL) begin
				prdata <= {30'h0, proceedInd, protectInd};
			end else if (paddr == SPU_OFF_BARRICADE) begin
				prdata <= {28'h0, barricade};
			end else if (paddr == SPU_OFF_VECTOR) begin
				prdata <= {16'h0, vector};
			end else if (paddr == SPU_OFF_STATUS) begin
				prdata <= {24'h0, barricadeLoaded, preempted, opViol, addrViolExt,
					addrViolInt, mode};
			end else begin
				prdata <= '0;
			end
		end
	end
endmodule : spu_storage_protect
`default_nettype wire

//--- inc/spu_pkg.sv
// constants and types for the storage protection unit
// Function
// R1: load-barricade stores a bank number; protected region starts at that bank's base.
// R2: upper limit is always top of memory; only lower boundary programmable.
// R3: checks act only with protect indicator on and standard mode; code still runs the proceed-enabled transfer start check in interrupt modes.
// R4: fifteen bank index registers sit in the first 60 locations of barricade bank.
// R5: bank index registers usable once a bank is loaded, protection or not.
// R6: top bit of five-bit modifier selects bank index registers in four-character mode.
// R7: trap taken only at run, op fetch, memory cycle, standard, no external pending.
// R8: taking the trap swaps sequence and trap vector registers, enters internal mode.
// R9: trap entry saves or changes no indicator and keeps addressing mode.
// R10: store-indicators clears violation indicators.
// R11: external interrupt preempts internal mode; internal never preempts external.
// R12: preemption of internal mode is recorded in bit one of fifth variant character.
// R13: result write at or above barricade, protected, standard, non-transfer, is violation.
// R14: reads and index use are fine; writing bank index registers is violation.
// R15: write violation sets address flag, inhibits writes until instruction ends.
// R16: vector then holds next op address; address registers keep stepping.
// R17: protected peripheral start address with proceed set aborts, flags, skips, traps.
// R18: peripheral transfers are checked only at extraction, on start address.
// R19: software places record marks below the protected region.
// R20: in interrupt modes only proceed-enabled peripheral start check applies.
// R21: privileged op fetch when protected flags op violation, backs up, traps.
// R22: proceed cleared after standard-mode op fetch and by store-indicators in interrupt modes.
package spu_pkg;
	localparam int SPU_AW = 16;
	localparam int SPU_BANK_W = 4;
	localparam int SPU_BANK_LSB = 12;
	localparam int SPU_MOD_W = 5;
	localparam logic [11:0] SPU_BANK_BASE = 12'h000;
	localparam logic [3:0] SPU_IDX_NONE = 4'h0;
	localparam logic [3:0] SPU_IDX_ONE = 4'h1;
	localparam logic [7:0] SPU_OFF_CTRL = 8'h00;
	localparam logic [7:0] SPU_OFF_BARRICADE = 8'h04;
	localparam logic [7:0] SPU_OFF_VECTOR = 8'h08;
	localparam logic [7:0] SPU_OFF_STATUS = 8'h0c;
	localparam int SPU_CTRL_PROTECT = 0;
	localparam int SPU_CTRL_PROCEED = 1;
	localparam int SPU_ST_MODE_LSB = 0;
	localparam int SPU_ST_ADDR_INT = 3;
	localparam int SPU_ST_ADDR_EXT = 4;
	localparam int SPU_ST_OPCODE = 5;
	localparam int SPU_ST_PREEMPT = 6;
	localparam int SPU_ST_LOADED = 7;
	localparam logic [SPU_BANK_W-1:0] SPU_BARRICADE_RST = 4'h0;
	localparam logic [SPU_AW-1:0] SPU_VECTOR_RST = 16'h0000;
	typedef enum logic [2:0] {
		MODE_STD = 3'b001,
		MODE_INT = 3'b010,
		MODE_EXT = 3'b100
	} spu_mode_type;
endpackage : spu_pkg

//--- testbench/spu_seq_model.sv
// sequencer stand-in granting op fetch slots
`timescale 1ns/100ps
`default_nettype none
module spu_seq_model
	import spu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic fetchOn,
	input wire logic trapTake,
	input wire logic [SPU_AW-1:0] trapVector,
	output logic runMode,
	output logic aboutToFetch,
	output logic memCycle,
	output logic [SPU_AW-1:0] seqAddr
);
	logic slot;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			slot <= 1'b0;
			seqAddr <= 16'h0200;
		end else begin
			slot <= ~slot;
			seqAddr <= trapTake ? trapVector : seqAddr + 16'h0001;
		end
	end
	// memory granted every other cycle only, so a trap may have to wait
	assign runMode = fetchOn;
	assign aboutToFetch = fetchOn;
	assign memCycle = fetchOn & slot;
endmodule : spu_seq_model
`default_nettype wire

//--- testbench/spu_storage_protect_assertions.sv
// checker for the storage protection unit
`timescale 1ns/100ps
`default_nettype none
module spu_storage_protect_assertions
	import spu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic runMode,
	input wire logic aboutToFetch,
	input wire logic memCycle,
	input wire logic extIntPending,
	input wire logic opFetch,
	input wire logic [SPU_AW-1:0] seqAddr,
	input wire logic trapTake,
	input wire logic [SPU_AW-1:0] trapVector,
	input wire logic resultWrite,
	input wire logic instrIsTransfer,
	input wire logic writeInhibit,
	input wire logic transferExtract,
	input wire logic transferAbort,
	input wire logic opAbort,
	input wire logic fourCharMode,
	input wire logic [SPU_MOD_W-1:0] addrModifier,
	input wire logic bankIndexSelect
);
	// registered select may only follow a bank-set modifier
	logic bankPick;
	assign bankPick = fourCharMode & addrModifier[SPU_MOD_W-1];
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence fetchSlot;
		runMode && aboutToFetch && memCycle && !extIntPending;
	endsequence
	sequence guardedWrite;
		resultWrite && !instrIsTransfer;
	endsequence
	a_trap_in_slot: assert property (trapTake |-> fetchSlot)
		else $error("trap outside a fetch slot");
	a_vector_swap: assert property (trapTake |=> trapVector == $past(seqAddr))
		else $error("vector not swapped");
	a_trap_once: assert property (trapTake |=> !trapTake)
		else $error("trap repeated");
	a_inhibit_cause: assert property ($rose(writeInhibit) |-> guardedWrite)
		else $error("inhibit without result write");
	a_inhibit_holds: assert property (writeInhibit && !opFetch |=> writeInhibit)
		else $error("inhibit dropped early");
	a_abort_at_extract: assert property (transferAbort |-> transferExtract)
		else $error("abort outside extraction");
	a_opabort_fetch: assert property (opAbort |-> opFetch)
		else $error("op abort without fetch");
	a_bank_select: assert property (bankIndexSelect |-> $past(bankPick))
		else $error("bank select without modifier");
	a_inhibit_ends: assert property (opFetch && !resultWrite |=> !writeInhibit || resultWrite)
		else $error("inhibit outlived its instruction");
endmodule : spu_storage_protect_assertions
bind spu_storage_protect spu_storage_protect_assertions chk_u (.*);
`default_nettype wire

//--- testbench/spu_storage_protect_bench.sv
// randomised bench for the storage protection unit
`timescale 1ns/100ps
`default_nettype none
module spu_storage_protect_bench
	import spu_pkg::*;
;
	logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
	logic pready, pslverr, loadBarricade = 1'b0, restoreIndicators = 1'b0, storeIndicators = 1'b0;
	// restore always turns both protect and proceed on
	logic restoreProtect = 1'b1, restoreProceed = 1'b1, resumeNormal = 1'b0, extIntTake = 1'b0;
	logic resumeToInternal = 1'b0, extIntPending = 1'b0, opFetch = 1'b0, opPrivileged = 1'b0;
	logic resultWrite = 1'b0, instrIsTransfer = 1'b0, transferExtract = 1'b0, fourCharMode = 1'b1;
	logic fetchOn = 1'b0, runMode, aboutToFetch, memCycle, trapTake, writeInhibit, transferAbort;
	logic opAbort, fifthVariantBit1, bankIndexSelect;
	logic [3:0] loadBank = 4'h0;
	logic [3:0] idx;
	logic [4:0] addrModifier = 5'h00;
	logic [7:0] paddr = 8'h00;
	logic [15:0] resultAddr = 16'h0000, transferStart = 16'h0000, base, at;
	logic [15:0] seqAddr, trapVector, bankIndexAddr;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int errors = 0, comparisons = 0, cycles = 0;
	spu_storage_protect dut_u (.*);
	spu_seq_model model_u (.*);
	always #25 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// slot n of the bank index set sits four characters per slot above the bank base
	function automatic logic [15:0] bank_slot(input logic [3:0] bank, input logic [3:0] n);
		bank_slot = {bank, 12'h000} + {10'h000, n - 4'h1, 2'b00};
	endfunction : bank_slot
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask : rdchk
	task automatic pulse(input logic [5:0] k);
		@(posedge clock);
		{loadBarricade, restoreIndicators, storeIndicators, extIntTake, resumeNormal, opFetch} <= k;
		@(posedge clock);
		{loadBarricade, restoreIndicators, storeIndicators, extIntTake, resumeNormal, opFetch} <= 6'h00;
	endtask : pulse
	task automatic act(input logic [4:0] k, input logic [15:0] a, input logic [2:0] exp);
		@(posedge clock);
		{resultWrite, instrIsTransfer, transferExtract, opFetch, opPrivileged} <= k;
		resultAddr <= a;
		transferStart <= a;
		@(negedge clock);
		check({writeInhibit, transferAbort, opAbort}, exp);
		@(posedge clock);
		{resultWrite, instrIsTransfer, transferExtract, opFetch, opPrivileged} <= 5'h00;
	endtask : act
	task automatic take_trap();
		int n;
		n = 0;
		@(posedge clock);
		fetchOn <= 1'b1;
		do begin
			@(negedge clock);
			n++;
		end while (trapTake !== 1'b1 && n < 9);
		at = seqAddr;
		@(posedge clock);
		fetchOn <= 1'b0;
		check(n < 9, 1'b1);
	endtask : take_trap
	initial begin
		rd = $urandom(98);
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rdchk(SPU_OFF_STATUS, 32'h0000_0001);
		apb(1'b0, 8'h10, 32'h0000_0000);
		check(perr, 1'b1);
		at = 16'($urandom);
		apb(1'b1, SPU_OFF_VECTOR, {16'h0000, at});
		rdchk(SPU_OFF_VECTOR, {16'h0000, at});
		base = {4'($urandom_range(14, 1)), 12'h000};
		loadBank <= base[15:12];
		pulse(6'h20);
		rdchk(SPU_OFF_STATUS, 32'h0000_0081);
		act(5'h10, base, 3'b000);
		@(posedge clock);
		idx = 4'($urandom_range(15, 1));
		addrModifier <= {1'b1, idx};
		@(posedge clock);
		addrModifier <= 5'h0f;
		@(negedge clock);
		check({bankIndexSelect, bankIndexAddr}, {1'b1, bank_slot(base[15:12], idx)});
		@(negedge clock);
		check(bankIndexSelect, 1'b0);
		@(posedge clock);
		fourCharMode <= 1'b0;
		addrModifier <= 5'h1f;
		@(posedge clock);
		fourCharMode <= 1'b1;
		addrModifier <= 5'h0f;
		@(negedge clock);
		check(bankIndexSelect, 1'b0);
		pulse(6'h10);
		act(5'h04, base | 16'($urandom_range(4095, 0)), 3'b010);
		take_trap();
		rdchk(SPU_OFF_VECTOR, {16'h0000, at});
		rdchk(SPU_OFF_STATUS, 32'h0000_008a);
		rdchk(SPU_OFF_CTRL, 32'h0000_0003);
		pulse(6'h08);
		rdchk(SPU_OFF_STATUS, 32'h0000_0082);
		rdchk(SPU_OFF_CTRL, 32'h0000_0001);
		act(5'h04, 16'hffff, 3'b000);
		pulse(6'h10);
		act(5'h04, base, 3'b010);
		rdchk(SPU_OFF_STATUS, 32'h0000_008a);
		pulse(6'h08);
		pulse(6'h04);
		rdchk(SPU_OFF_STATUS, 32'h0000_00c4);
		check(fifthVariantBit1, 1'b1);
		pulse(6'h10);
		act(5'h04, base, 3'b010);
		rdchk(SPU_OFF_STATUS, 32'h0000_00d4);
		pulse(6'h08);
		@(posedge clock);
		resumeToInternal <= 1'b1;
		pulse(6'h02);
		rdchk(SPU_OFF_STATUS, 32'h0000_0082);
		check(fifthVariantBit1, 1'b0);
		resumeToInternal <= 1'b0;
		pulse(6'h02);
		apb(1'b0, SPU_OFF_STATUS, 32'h0000_0000);
		check(rd[2:0], 3'b001);
		pulse(6'h10);
		act(5'h04, base - 16'h0001, 3'b000);
		act(5'h10, base - 16'($urandom_range(4096, 1)), 3'b000);
		act(5'h10, base, 3'b100);
		pulse(6'h01);
		act(5'h18, 16'hffff, 3'b000);
		act(5'h10, 16'hffff, 3'b100);
		@(negedge clock);
		check(writeInhibit, 1'b1);
		pulse(6'h01);
		@(negedge clock);
		check(writeInhibit, 1'b0);
		rdchk(SPU_OFF_CTRL, 32'h0000_0001);
		act(5'h03, 16'h0000, 3'b001);
		@(posedge clock);
		extIntPending <= 1'b1;
		fetchOn <= 1'b1;
		repeat (3) @(negedge clock);
		check(trapTake, 1'b0);
		@(posedge clock);
		extIntPending <= 1'b0;
		fetchOn <= 1'b0;
		take_trap();
		rdchk(SPU_OFF_STATUS, 32'h0000_00aa);
		rdchk(SPU_OFF_VECTOR, {16'h0000, at});
		give_verdict();
	end
endmodule : spu_storage_protect_bench
`default_nettype wire
